// ==== rtcpt_map.svh ====
// register map, field positions, reset values and counts of the real-time counter
// Summary of operation
// R01: trim sign 0 slows count, 1 speeds it
// R02: software keeps prescaler at least halve setting
// R03: error field gives clocks per million cycles
// R04: software supplies trim value from calibration
// R05: two-bit source choice selects RTC clock
// R06: 16-bit tick count, reset zero, low byte first
// R07: count and top writes act after two RTC cycles
// R08: software waits count busy clear before writing
// R09: software waits top busy clear before writing
// R10: 16-bit wrap top, reset all ones
// R11: 16-bit match value, reset zero
// R12: interval code selects 4 to 32768 cycles
// R13: tick generator runs only while enabled
// R14: tick busy high while control syncs
// R15: tick interrupt forwarded only when enabled
// R16: tick flag set per tick, write one clears
// R17: run-while-halted decides debug halt behaviour
// R18: count wraps at top, sets wrap flag
// R19: count equal match sets compare flag
// R20: trim applied only while trim enable set
// R21: free divider; irq is flag and enable
// R22: busy held until new value in force
`ifndef RTCPT_MAP_SVH
`define RTCPT_MAP_SVH
`define RTCPT_OFS_CONTROL 5'h00
`define RTCPT_OFS_STATUS 5'h01
`define RTCPT_OFS_FLAGS 5'h03
`define RTCPT_OFS_TRIM 5'h06
`define RTCPT_OFS_SOURCE 5'h07
`define RTCPT_OFS_COUNT_LO 5'h08
`define RTCPT_OFS_COUNT_HI 5'h09
`define RTCPT_OFS_TOP_LO 5'h0a
`define RTCPT_OFS_TOP_HI 5'h0b
`define RTCPT_OFS_MATCH_LO 5'h0c
`define RTCPT_OFS_MATCH_HI 5'h0d
`define RTCPT_OFS_TICK_CTRL 5'h10
`define RTCPT_OFS_TICK_STAT 5'h11
`define RTCPT_OFS_TICK_IE 5'h12
`define RTCPT_OFS_TICK_FLAG 5'h13
`define RTCPT_OFS_TICK_DBG 5'h15
`define RTCPT_BIT_COUNT_EN 0
`define RTCPT_BIT_TRIM_EN 2
`define RTCPT_BIT_CNT_BUSY 1
`define RTCPT_BIT_TOP_BUSY 2
`define RTCPT_BIT_CMP 1
`define RTCPT_BIT_WRAP 0
`define RTCPT_BIT_SIGN 7
`define RTCPT_RST_COUNT 16'h0000
`define RTCPT_RST_TOP 16'hffff
`define RTCPT_RST_MATCH 16'h0000
`define RTCPT_RST_BYTE 8'h00
`define RTCPT_SYNC_CYCLES 2'h2
`define RTCPT_TRIM_INTERVAL 1000000
`endif

// ==== rtcpt_pkg.sv ====
// types of the real-time counter
package rtcpt_pkg;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rtcpt_bus_t;
   typedef enum logic [1:0] {
      RTCPT_SRC_FAST = 2'h0,
      RTCPT_SRC_SLOW = 2'h1,
      RTCPT_SRC_CRYSTAL = 2'h2,
      RTCPT_SRC_OUTSIDE = 2'h3
   } rtcpt_src_t;
   typedef struct packed {
      logic spare;
      logic [3:0] interval;
      logic [1:0] unused;
      logic tick_enable;
   } rtcpt_tick_ctrl_t;
endpackage

// ==== rtcpt_top.sv ====
// real-time counter with drift trim, wrap, match and periodic tick
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtcpt_map.svh"
module rtcpt_top #(
   parameter int TRIM_INTERVAL = `RTCPT_TRIM_INTERVAL
) (
   input wire logic clk,
   input wire logic nrst,
   input wire rtcpt_pkg::rtcpt_bus_t bus_i,
   input wire logic [3:0] src_tick,
   input wire logic debug_halt,
   output logic [7:0] rdata_r,
   output logic tick_irq_r
);
   // one-cycle pulses, one per RTC clock period of each source
   logic rtc_t;
   rtcpt_pkg::rtcpt_src_t source_choice_r;
   logic [7:0] control_r, drift_trim_r, tick_ie_r, tick_dbg_r;
   logic [15:0] tick_count_r, wrap_top_r, match_value_r;
   logic [15:0] count_shadow_r, top_shadow_r;
   logic [7:0] tick_shadow_r;
   rtcpt_pkg::rtcpt_tick_ctrl_t tick_ctrl_r;
   logic count_busy_r, top_busy_r, tick_busy_r;
   logic [1:0] count_sync_r, top_sync_r, tick_sync_r;
   logic wrap_flag_r, cmp_flag_r, tick_flag_r;
   logic [19:0] ppm_cnt_r;
   logic [6:0] corr_left_r;
   logic extra_pend_r, cnt_tick;
   logic [14:0] pit_div_r;
   logic pit_run, tick_hit;
   logic wr_count, wr_top, wr_tick, wr_flags, wr_tick_flag;

   function automatic logic hit_fn(input logic [3:0] code, input logic [14:0] div);
      logic [15:0] mask;
      mask = (16'h0002 << code) - 16'h0001;
      hit_fn = (code != 4'h0) && (code != 4'hf) && ((({1'b0, div}) & mask) == mask);
   endfunction

   function automatic logic [1:0] sync_step(input logic busy, input logic [1:0] cnt);
      sync_step = (busy && rtc_t) ? cnt + 2'h1 : cnt;
   endfunction

   // the selected source pulse is the RTC clock of the whole block
   assign rtc_t = src_tick[source_choice_r]; // [R05]
   assign wr_count = bus_i.wr && (bus_i.addr == `RTCPT_OFS_COUNT_LO || bus_i.addr == `RTCPT_OFS_COUNT_HI);
   assign wr_top = bus_i.wr && (bus_i.addr == `RTCPT_OFS_TOP_LO || bus_i.addr == `RTCPT_OFS_TOP_HI);
   assign wr_tick = bus_i.wr && bus_i.addr == `RTCPT_OFS_TICK_CTRL;
   assign wr_flags = bus_i.wr && bus_i.addr == `RTCPT_OFS_FLAGS;
   assign wr_tick_flag = bus_i.wr && bus_i.addr == `RTCPT_OFS_TICK_FLAG && bus_i.wdata[0];

   // plain configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         control_r <= `RTCPT_RST_BYTE;
         drift_trim_r <= `RTCPT_RST_BYTE;
         source_choice_r <= rtcpt_pkg::RTCPT_SRC_FAST;
         match_value_r <= `RTCPT_RST_MATCH; // [R11]
         tick_ie_r <= `RTCPT_RST_BYTE;
         tick_dbg_r <= `RTCPT_RST_BYTE;
      end else if (bus_i.wr) begin
         unique case (bus_i.addr)
            `RTCPT_OFS_CONTROL: control_r <= bus_i.wdata & 8'h05;
            `RTCPT_OFS_TRIM: drift_trim_r <= bus_i.wdata; // [R04]
            `RTCPT_OFS_SOURCE: source_choice_r <= rtcpt_pkg::rtcpt_src_t'(bus_i.wdata[1:0]); // [R05]
            `RTCPT_OFS_MATCH_LO: match_value_r[7:0] <= bus_i.wdata; // [R11]
            `RTCPT_OFS_MATCH_HI: match_value_r[15:8] <= bus_i.wdata;
            `RTCPT_OFS_TICK_IE: tick_ie_r <= bus_i.wdata & 8'h01;
            `RTCPT_OFS_TICK_DBG: tick_dbg_r <= bus_i.wdata & 8'h01;
            default: ;
         endcase
      end
   end

   // shadows take the bus byte now; the live copy follows after two RTC cycles
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_shadow_r <= `RTCPT_RST_COUNT;
         top_shadow_r <= `RTCPT_RST_TOP;
         tick_shadow_r <= `RTCPT_RST_BYTE;
      end else if (bus_i.wr) begin
         unique case (bus_i.addr)
            `RTCPT_OFS_COUNT_LO: count_shadow_r[7:0] <= bus_i.wdata; // [R06]
            `RTCPT_OFS_COUNT_HI: count_shadow_r[15:8] <= bus_i.wdata;
            `RTCPT_OFS_TOP_LO: top_shadow_r[7:0] <= bus_i.wdata; // [R10]
            `RTCPT_OFS_TOP_HI: top_shadow_r[15:8] <= bus_i.wdata;
            `RTCPT_OFS_TICK_CTRL: tick_shadow_r <= bus_i.wdata & 8'h79;
            default: ;
         endcase
      end
   end

   // busy flags: a new write restarts the two-cycle wait
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_busy_r <= 1'b0;
         top_busy_r <= 1'b0;
         tick_busy_r <= 1'b0;
         count_sync_r <= 2'h0;
         top_sync_r <= 2'h0;
         tick_sync_r <= 2'h0;
      end else begin
         count_sync_r <= wr_count ? 2'h0 : sync_step(count_busy_r, count_sync_r); // [R07]
         top_sync_r <= wr_top ? 2'h0 : sync_step(top_busy_r, top_sync_r);
         tick_sync_r <= wr_tick ? 2'h0 : sync_step(tick_busy_r, tick_sync_r);
         count_busy_r <= wr_count || (count_busy_r && sync_step(1'b1, count_sync_r) != `RTCPT_SYNC_CYCLES); // [R22]
         top_busy_r <= wr_top || (top_busy_r && sync_step(1'b1, top_sync_r) != `RTCPT_SYNC_CYCLES); // [R22]
         tick_busy_r <= wr_tick || (tick_busy_r && sync_step(1'b1, tick_sync_r) != `RTCPT_SYNC_CYCLES); // [R14]
      end
   end

   // live top and tick control copies, loaded when the wait ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrap_top_r <= `RTCPT_RST_TOP; // [R10]
         tick_ctrl_r <= '0;
      end else begin
         if (top_busy_r && !wr_top && rtc_t && top_sync_r == `RTCPT_SYNC_CYCLES - 2'h1) begin
            wrap_top_r <= top_shadow_r; // [R07]
         end
         if (tick_busy_r && !wr_tick && rtc_t && tick_sync_r == `RTCPT_SYNC_CYCLES - 2'h1) begin
            tick_ctrl_r <= rtcpt_pkg::rtcpt_tick_ctrl_t'(tick_shadow_r);
         end
      end
   end

   // drift trim: the first N RTC cycles of each million are dropped or doubled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ppm_cnt_r <= 20'h00000;
         corr_left_r <= 7'h00;
         extra_pend_r <= 1'b0;
      end else begin
         extra_pend_r <= 1'b0;
         if (rtc_t) begin
            if (ppm_cnt_r == 20'(TRIM_INTERVAL - 1)) begin
               ppm_cnt_r <= 20'h00000;
               corr_left_r <= drift_trim_r[6:0]; // [R03]
            end else begin
               ppm_cnt_r <= ppm_cnt_r + 20'h00001;
               if (corr_left_r != 7'h00 && control_r[`RTCPT_BIT_TRIM_EN]) begin
                  corr_left_r <= corr_left_r - 7'h01;
                  // an extra pulse one clk later; clk is far faster than any source
                  extra_pend_r <= drift_trim_r[`RTCPT_BIT_SIGN]; // [R01]
               end
            end
         end
      end
   end

   // slower: the RTC pulse is swallowed; faster: an extra pulse follows it
   assign cnt_tick = extra_pend_r || (rtc_t && !(control_r[`RTCPT_BIT_TRIM_EN] && corr_left_r != 7'h00
                     && ppm_cnt_r != 20'(TRIM_INTERVAL - 1) && !drift_trim_r[`RTCPT_BIT_SIGN])); // [R01] [R20]

   // tick count with wrap at top
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_count_r <= `RTCPT_RST_COUNT; // [R06]
      end else if (count_busy_r && !wr_count && rtc_t && count_sync_r == `RTCPT_SYNC_CYCLES - 2'h1) begin
         tick_count_r <= count_shadow_r; // [R07]
      end else if (cnt_tick && control_r[`RTCPT_BIT_COUNT_EN]) begin
         tick_count_r <= (tick_count_r == wrap_top_r) ? 16'h0000 : tick_count_r + 16'h0001; // [R18]
      end
   end

   // wrap and compare flags; a hardware set beats a same-cycle clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrap_flag_r <= 1'b0;
         cmp_flag_r <= 1'b0;
      end else begin
         if (cnt_tick && control_r[`RTCPT_BIT_COUNT_EN] && tick_count_r == wrap_top_r) begin
            wrap_flag_r <= 1'b1; // [R18]
         end else if (wr_flags && bus_i.wdata[`RTCPT_BIT_WRAP]) begin
            wrap_flag_r <= 1'b0; // [R18]
         end
         if (cnt_tick && control_r[`RTCPT_BIT_COUNT_EN] && tick_count_r == match_value_r) begin
            cmp_flag_r <= 1'b1; // [R19]
         end else if (wr_flags && bus_i.wdata[`RTCPT_BIT_CMP]) begin
            cmp_flag_r <= 1'b0; // [R19]
         end
      end
   end

   // periodic tick: free divider on the raw RTC clock, frozen in debug unless told to run
   assign pit_run = tick_ctrl_r.tick_enable && rtc_t && (tick_dbg_r[0] || !debug_halt); // [R13] [R17]
   assign tick_hit = pit_run && hit_fn(tick_ctrl_r.interval, pit_div_r); // [R12]

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pit_div_r <= 15'h0000;
      end else if (!tick_ctrl_r.tick_enable) begin
         pit_div_r <= 15'h0000; // [R13]
      end else if (pit_run) begin
         pit_div_r <= pit_div_r + 15'h0001; // [R21]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_flag_r <= 1'b0;
      end else if (tick_hit) begin
         tick_flag_r <= 1'b1; // [R16]
      end else if (wr_tick_flag) begin
         tick_flag_r <= 1'b0; // [R16]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_irq_r <= 1'b0;
      end else begin
         tick_irq_r <= (tick_hit || (tick_flag_r && !wr_tick_flag)) && tick_ie_r[0]; // [R15] [R21]
      end
   end

   // read data stand in the cycle after the strobe only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= `RTCPT_RST_BYTE;
      end else if (!bus_i.rd) begin
         rdata_r <= 8'h00;
      end else begin
         unique case (bus_i.addr)
            `RTCPT_OFS_CONTROL: rdata_r <= control_r;
            `RTCPT_OFS_STATUS: rdata_r <= {5'h00, top_busy_r, count_busy_r, 1'b0};
            `RTCPT_OFS_FLAGS: rdata_r <= {6'h00, cmp_flag_r, wrap_flag_r};
            `RTCPT_OFS_TRIM: rdata_r <= drift_trim_r;
            `RTCPT_OFS_SOURCE: rdata_r <= {6'h00, source_choice_r};
            `RTCPT_OFS_COUNT_LO: rdata_r <= tick_count_r[7:0];
            `RTCPT_OFS_COUNT_HI: rdata_r <= tick_count_r[15:8];
            `RTCPT_OFS_TOP_LO: rdata_r <= top_shadow_r[7:0];
            `RTCPT_OFS_TOP_HI: rdata_r <= top_shadow_r[15:8];
            `RTCPT_OFS_MATCH_LO: rdata_r <= match_value_r[7:0];
            `RTCPT_OFS_MATCH_HI: rdata_r <= match_value_r[15:8];
            `RTCPT_OFS_TICK_CTRL: rdata_r <= tick_shadow_r;
            `RTCPT_OFS_TICK_STAT: rdata_r <= {7'h00, tick_busy_r}; // [R14]
            `RTCPT_OFS_TICK_IE: rdata_r <= tick_ie_r;
            `RTCPT_OFS_TICK_FLAG: rdata_r <= {7'h00, tick_flag_r};
            `RTCPT_OFS_TICK_DBG: rdata_r <= tick_dbg_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   // checks
   sequence seq_count_write;
      wr_count;
   endsequence
   sequence seq_count_done;
      count_busy_r && !wr_count && rtc_t && count_sync_r == 2'h1;
   endsequence

   a_count_busy_set: assert property (@(posedge clk) disable iff (!nrst) seq_count_write |=> count_busy_r) // [R22]
      else $error("count busy not raised by write");
   a_count_sync_two: assert property (@(posedge clk) disable iff (!nrst)
      seq_count_done |=> !count_busy_r && tick_count_r == $past(count_shadow_r)) // [R07]
      else $error("count not loaded at second rtc cycle");
   a_tick_busy_set: assert property (@(posedge clk) disable iff (!nrst) wr_tick |=> tick_busy_r ##0 tick_sync_r == 2'h0) // [R14]
      else $error("tick busy not raised");
   a_wrap_to_zero: assert property (@(posedge clk) disable iff (!nrst)
      cnt_tick && control_r[0] && tick_count_r == wrap_top_r && !count_busy_r |=> tick_count_r == 16'h0000 && wrap_flag_r) // [R18]
      else $error("count did not wrap at top");
   a_match_flag: assert property (@(posedge clk) disable iff (!nrst)
      cnt_tick && control_r[0] && tick_count_r == match_value_r |=> cmp_flag_r) // [R19]
      else $error("compare flag missing");
   a_tick_flag_set: assert property (@(posedge clk) disable iff (!nrst) tick_hit |=> tick_flag_r ##1 tick_flag_r || $past(wr_tick_flag)) // [R16]
      else $error("tick flag not set");
   a_irq_gated: assert property (@(posedge clk) disable iff (!nrst) tick_irq_r |-> $past(tick_ie_r[0]) && tick_flag_r) // [R15]
      else $error("tick irq without enable or flag");
   a_pit_disabled: assert property (@(posedge clk) disable iff (!nrst) !tick_ctrl_r.tick_enable |-> !tick_hit) // [R13]
      else $error("tick while disabled");
   a_pit_halted: assert property (@(posedge clk) disable iff (!nrst)
      debug_halt && !tick_dbg_r[0] && tick_ctrl_r.tick_enable |=> $stable(pit_div_r)) // [R17]
      else $error("tick divider moved in debug halt");
   a_trim_off: assert property (@(posedge clk) disable iff (!nrst) !control_r[2] && !extra_pend_r |-> cnt_tick == rtc_t) // [R20]
      else $error("trim acted while disabled");
   a_trim_fast: assert property (@(posedge clk) disable iff (!nrst)
      rtc_t && control_r[2] && drift_trim_r[7] && corr_left_r != 7'h00 && ppm_cnt_r != 20'(TRIM_INTERVAL - 1)
      |=> extra_pend_r && cnt_tick) // [R01] [R03]
      else $error("negative trim gave no extra count");

   // load steps of the top and tick control synchronisers
   sequence seq_top_done;
      top_busy_r && !wr_top && rtc_t && top_sync_r == 2'h1;
   endsequence
   sequence seq_tick_done;
      tick_busy_r && !wr_tick && rtc_t && tick_sync_r == 2'h1;
   endsequence

   a_top_busy_set: assert property (@(posedge clk) disable iff (!nrst) // [R22]
      wr_top
      |=> top_busy_r)
      else $error("top busy not raised by write");

   a_top_sync_two: assert property (@(posedge clk) disable iff (!nrst) // [R07]
      seq_top_done
      |=> !top_busy_r && wrap_top_r == $past(top_shadow_r))
      else $error("top not loaded at second rtc cycle");

   a_tick_ctrl_load: assert property (@(posedge clk) disable iff (!nrst) // [R14]
      seq_tick_done
      |=> !tick_busy_r && tick_ctrl_r == rtcpt_pkg::rtcpt_tick_ctrl_t'($past(tick_shadow_r)))
      else $error("tick control not loaded at second rtc cycle");

   // busy may only drop on an rtc pulse, never between them
   a_count_busy_hold: assert property (@(posedge clk) disable iff (!nrst) // [R22]
      count_busy_r && !rtc_t
      |=> count_busy_r)
      else $error("count busy dropped without rtc pulse");

   a_top_busy_hold: assert property (@(posedge clk) disable iff (!nrst) // [R22]
      top_busy_r && !rtc_t
      |=> top_busy_r)
      else $error("top busy dropped without rtc pulse");

   a_tick_busy_hold: assert property (@(posedge clk) disable iff (!nrst) // [R14]
      tick_busy_r && !rtc_t
      |=> tick_busy_r)
      else $error("tick busy dropped without rtc pulse");

   a_irq_follows: assert property (@(posedge clk) disable iff (!nrst) // [R21]
      tick_flag_r && tick_ie_r[0] && !wr_tick_flag
      |=> tick_irq_r)
      else $error("irq missing with flag and enable");

   a_irq_masked: assert property (@(posedge clk) disable iff (!nrst) // [R15]
      !tick_ie_r[0]
      |=> !tick_irq_r)
      else $error("irq raised while masked");

   a_tick_flag_clear: assert property (@(posedge clk) disable iff (!nrst) // [R16]
      wr_tick_flag && !tick_hit
      |=> !tick_flag_r)
      else $error("tick flag not cleared");

   a_wrap_clear: assert property (@(posedge clk) disable iff (!nrst) // [R18]
      wr_flags && bus_i.wdata[0] && !(cnt_tick && control_r[0] && tick_count_r == wrap_top_r)
      |=> !wrap_flag_r)
      else $error("wrap flag not cleared");

   a_cmp_clear: assert property (@(posedge clk) disable iff (!nrst) // [R19]
      wr_flags && bus_i.wdata[1] && !(cnt_tick && control_r[0] && tick_count_r == match_value_r)
      |=> !cmp_flag_r)
      else $error("compare flag not cleared");

   a_count_hold: assert property (@(posedge clk) disable iff (!nrst) // [R06]
      !control_r[0] && !(count_busy_r && rtc_t && count_sync_r == 2'h1)
      |=> $stable(tick_count_r))
      else $error("count moved while disabled");

   a_count_step: assert property (@(posedge clk) disable iff (!nrst) // [R18]
      cnt_tick && control_r[0] && tick_count_r != wrap_top_r && !(count_busy_r && rtc_t && count_sync_r == 2'h1)
      |=> tick_count_r == $past(tick_count_r) + 16'h0001)
      else $error("count did not step by one");

   // a dropped pulse must not reach the counter
   a_trim_slow: assert property (@(posedge clk) disable iff (!nrst) // [R01]
      rtc_t && control_r[2] && !drift_trim_r[7] && corr_left_r != 7'h00 && ppm_cnt_r != 20'(TRIM_INTERVAL - 1) && !extra_pend_r
      |-> !cnt_tick)
      else $error("positive trim did not drop pulse");

   a_trim_load: assert property (@(posedge clk) disable iff (!nrst) // [R03]
      rtc_t && ppm_cnt_r == 20'(TRIM_INTERVAL - 1)
      |=> corr_left_r == $past(drift_trim_r[6:0]))
      else $error("trim amount not loaded at interval end");

   a_pit_cleared: assert property (@(posedge clk) disable iff (!nrst) // [R13]
      !tick_ctrl_r.tick_enable
      |=> pit_div_r == 15'h0000)
      else $error("tick divider not cleared while disabled");

   a_pit_step: assert property (@(posedge clk) disable iff (!nrst) // [R21]
      pit_run
      |=> pit_div_r == $past(pit_div_r) + 15'h0001)
      else $error("tick divider did not step");

   a_no_tick_code: assert property (@(posedge clk) disable iff (!nrst) // [R12]
      tick_ctrl_r.interval == 4'h0 || tick_ctrl_r.interval == 4'hf
      |-> !tick_hit)
      else $error("tick issued for off or reserved code");
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the real-time counter
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk;
   logic nrst;
   logic debug_halt;
   logic [3:0] src_tick;
   logic [7:0] rdata_r;
   logic tick_irq_r;
   rtcpt_pkg::rtcpt_bus_t bus;
   int sel;
   int miscompares = 0;
   int num_checks = 0;
   localparam logic [4:0] map_list [17] = '{5'h00, 5'h01, 5'h03, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b,
      5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15};
   localparam int code_list [5] = '{0, 15, 3, 2, 1};
   // short trim interval keeps the run brief
   rtcpt_top #(.TRIM_INTERVAL(64)) i_rtcpt_top (.clk(clk), .nrst(nrst), .bus_i(bus), .src_tick(src_tick),
      .debug_halt(debug_halt), .rdata_r(rdata_r), .tick_irq_r(tick_irq_r));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata_r;
   endtask
   task automatic rdc(string what, logic [4:0] a, logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(what, {8'h00, d}, {8'h00, exp});
   endtask
   task automatic rd16(logic [4:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(5'(a + 5'h01), v[15:8]);
   endtask
   // pulses keep three idle clocks so a doubled pulse still fits between them
   task automatic pulse(int n, logic [3:0] m = 4'h0);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         src_tick <= (m == 4'h0) ? 4'(4'h1 << sel) : m;
         @(posedge clk);
         src_tick <= 4'h0;
         repeat (2) @(posedge clk);
      end
   endtask
   task automatic wait_tick();
      logic [7:0] d;
      for (int i = 0; i < 40; i++) begin
         pulse(1);
         rd(5'h13, d);
         if (d[0] === 1'b1) return;
      end
      chk("tick wait", 16'h0000, 16'h0001);
      give_verdict();
   endtask
   task automatic t_reset();
      foreach (map_list[i]) rdc("reset value", map_list[i], (map_list[i][4:1] == 4'h5) ? 8'hff : 8'h00);
   endtask
   task automatic t_rw();
      wr(5'h0c, 8'ha5);
      wr(5'h0d, 8'h3c);
      wr(5'h06, 8'h85);
      wr(5'h07, 8'h02);
      wr(5'h11, 8'hff);
      wr(5'h0e, 8'hff);
      wr(5'h15, 8'hff);
      rdc("match lo", 5'h0c, 8'ha5);
      rdc("match hi", 5'h0d, 8'h3c);
      rdc("trim", 5'h06, 8'h85);
      rdc("source", 5'h07, 8'h02);
      rdc("tick status", 5'h11, 8'h00);
      rdc("unmapped", 5'h0e, 8'h00);
      rdc("debug ctrl", 5'h15, 8'h01);
      wr(5'h06, 8'h00);
      wr(5'h07, 8'h00);
      wr(5'h15, 8'h00);
   endtask
   task automatic t_sync();
      rdc("sync idle", 5'h01, 8'h00);
      wr(5'h08, 8'h05);
      rdc("count busy", 5'h01, 8'h02);
      pulse(1);
      rdc("count early", 5'h08, 8'h00);
      rdc("count busy", 5'h01, 8'h02);
      pulse(1);
      rdc("count late", 5'h08, 8'h05);
      rdc("count idle", 5'h01, 8'h00);
      wr(5'h0a, 8'h07);
      pulse(1);
      wr(5'h0b, 8'h00);
      pulse(1);
      rdc("top restart", 5'h01, 8'h04);
      pulse(1);
      rdc("top idle", 5'h01, 8'h00);
   endtask
   task automatic t_wrap();
      wr(5'h0c, 8'h06);
      wr(5'h0d, 8'h00);
      wr(5'h00, 8'h01);
      pulse(1);
      rdc("flags at 6", 5'h03, 8'h00);
      pulse(1);
      rdc("flags at 7", 5'h03, 8'h02);
      pulse(1);
      rdc("flags wrap", 5'h03, 8'h03);
      rdc("count wrap", 5'h08, 8'h00);
      wr(5'h03, 8'h03);
      rdc("flags clear", 5'h03, 8'h00);
   endtask
   task automatic t_source();
      for (int s = 0; s < 4; s++) begin
         wr(5'h07, 8'(s));
         sel = s;
         pulse(2, 4'(~(4'h1 << s)));
         rdc("other source", 5'h08, 8'(s));
         pulse(1);
         rdc("chosen source", 5'h08, 8'(s + 1));
      end
   endtask
   task automatic t_trim();
      logic [7:0] ctrl [3] = '{8'h01, 8'h05, 8'h05};
      logic [7:0] trim [3] = '{8'h04, 8'h04, 8'h84};
      logic [15:0] delta [3] = '{16'd128, 16'd120, 16'd136};
      logic [15:0] c0;
      logic [15:0] c1;
      wr(5'h0a, 8'hff);
      wr(5'h0b, 8'hff);
      pulse(2);
      for (int k = 0; k < 3; k++) begin
         wr(5'h06, trim[k]); // prescaler lies outside, nothing to keep
         wr(5'h00, ctrl[k]);
         // the trim loads at an interval end, so let one pass before measuring
         pulse(64);
         rd16(5'h08, c0);
         pulse(128);
         rd16(5'h08, c1);
         chk("trimmed count", 16'(c1 - c0), delta[k]);
      end
      wr(5'h06, 8'h00);
   endtask
   task automatic t_tick(int code);
      int period;
      period = (code >= 1 && code <= 14) ? (2 << code) : 0;
      wr(5'h10, {1'b0, 4'(code), 3'b001});
      rdc("tick busy", 5'h11, 8'h01);
      pulse(2);
      rdc("tick idle", 5'h11, 8'h00);
      // a flag left from the last code would end the wait at once
      wr(5'h13, 8'h01);
      if (period == 0) begin
         pulse(40);
         rdc("no tick", 5'h13, 8'h00);
         return;
      end
      wait_tick();
      wr(5'h13, 8'h01);
      pulse(period - 1);
      rdc("tick early", 5'h13, 8'h00);
      pulse(1);
      rdc("tick due", 5'h13, 8'h01);
   endtask
   task automatic t_irq_dbg();
      wait_tick();
      chk("irq masked", {15'h0, tick_irq_r}, 16'h0000);
      wr(5'h12, 8'h01);
      @(posedge clk);
      #1 chk("irq on", {15'h0, tick_irq_r}, 16'h0001);
      wr(5'h13, 8'h01);
      @(posedge clk);
      #1 chk("irq cleared", {15'h0, tick_irq_r}, 16'h0000);
      wait_tick();
      wr(5'h13, 8'h01);
      debug_halt <= 1'b1;
      pulse(8);
      rdc("halted", 5'h13, 8'h00);
      wr(5'h15, 8'h01);
      pulse(4);
      rdc("runs halted", 5'h13, 8'h01);
      debug_halt <= 1'b0;
      wr(5'h10, 8'h08);
      pulse(2);
      wr(5'h13, 8'h01);
      pulse(8);
      rdc("disabled", 5'h13, 8'h00);
   endtask
   initial begin
      nrst = 1'b0;
      bus = '0;
      src_tick = 4'h0;
      debug_halt = 1'b0;
      sel = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_rw();
      t_sync();
      t_wrap();
      t_source();
      t_trim();
      foreach (code_list[i]) t_tick(code_list[i]);
      t_irq_dbg();
      give_verdict();
   end
endmodule
`default_nettype wire
